// ---- rtl/cls_top.sv ----
// Purpose: Customizable logic sequencer with AXI4-Lite settings
// Assumes: one 25 MHz clock, din from pins, analog words same clock
// Notes: one step evaluated per clock after each period tick
//
// Functional notes
// - Mode 0 disables the sequencer and clears outputs; mode 1 runs it.
// - Exactly fourteen configurable steps form the sequence.
// - Selector 1..1999 is a digital logic/timer step, first parameter is time.
// - Selector 2001..3999 is an analog step with analog and digital result.
// - Selector 4001..5999 is a mixed step giving an analog result.
// - Each type offers its own set of operations.
// - Step n uses settings 5n-4..5n; result goes to its own signal.
// - Seven outputs, each with its own source and function setting.
// - The whole sequence repeats every five milliseconds.
// - Digital selector 0 keeps the step output off.
// - Selector 11 is an on-delay timer.
// - Selector 12 is an off-delay timer.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cls_top
  import cls_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = PERIOD_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive signals in
  input wire logic [NDIN-1:0] din,
  input wire logic [15:0] ain0,
  input wire logic [15:0] ain1,
  input wire logic [15:0] ain2,
  input wire logic [15:0] ain3,
  // Sequencer results
  output logic logic_active,
  output logic [NSTEP-1:0] step_result,
  output logic [NOUT-1:0] logic_out,
  output logic [15:0] logic_out_function_assign [NOUT]
);
  //----------------------------------------------------------
  // Settings storage and bus slave
  //----------------------------------------------------------
  logic [15:0] cfg [NCFG];
  logic aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [6:0] aw_idx, next_aw_idx;
  logic [15:0] wd, next_wd;
  logic [1:0] ws, next_ws;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic do_wr;
  logic [6:0] ar_idx;
  logic [NDIN-1:0] s1, s2, s3, dfilt, next_dfilt;
  cls_sq_t sq, next_sq;
  logic [3:0] idx, next_idx;
  logic [TCNT_W-1:0] tcnt, next_tcnt;
  logic tick;
  logic st_pa [NSTEP];
  logic st_pl [NSTEP];
  logic st_lff [NSTEP];
  logic st_tout [NSTEP];
  logic [15:0] st_cnt [NSTEP];
  logic [15:0] st_ana [NSTEP];
  logic n_pa, n_pl, n_lff, n_tout;
  logic [15:0] n_cnt, n_ana;
  logic [6:0] base;
  logic da, db;
  logic [15:0] aa, ab;
  logic mode_on;
  logic [NOUT-1:0] next_out;

  // Writable or readable index check; gaps answer with an error
  function automatic logic idx_ok(input logic [6:0] i, input logic rd);
    idx_ok = (i <= IDX_OSELN) || (i >= IDX_OFUN0 && i <= IDX_OFUNN) || (rd && i == IDX_STATUS);
  endfunction : idx_ok

  // Status word: running flag and digital step results
  function automatic logic [31:0] status_word(input logic run, input logic [NSTEP-1:0] r);
    status_word = {16'h0000, 1'b0, run, r};
  endfunction : status_word

  assign s_axi_awready = !aw_hold && !bvalid;
  assign s_axi_wready = !w_hold && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign ar_idx = s_axi_araddr[8:2];
  assign do_wr = aw_hold && w_hold && !bvalid && idx_ok(aw_idx, 1'b0);

  // Address and data taken in either order; response after both
  always_comb
  begin
    next_aw_hold = aw_hold;
    next_aw_idx = aw_idx;
    next_w_hold = w_hold;
    next_wd = wd;
    next_ws = ws;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_hold = 1'b1;
      next_aw_idx = (s_axi_awaddr[ADDR_W-1:9] == '0) ? s_axi_awaddr[8:2] : 7'h7f;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_hold = 1'b1;
      next_wd = s_axi_wdata[15:0];
      next_ws = s_axi_wstrb[1:0];
    end
    if (aw_hold && w_hold && !bvalid)
    begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = idx_ok(aw_idx, 1'b0) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      if (s_axi_araddr[ADDR_W-1:9] != '0 || !idx_ok(ar_idx, 1'b1))
      begin
        next_rresp = RESP_SLVERR;
        next_rdata = 32'h0000_0000;
      end
      else
      begin
        next_rresp = RESP_OKAY;
        next_rdata = (ar_idx == IDX_STATUS) ? status_word(sq == SQ_RUN, step_result) : {16'h0000, cfg[ar_idx]};
      end
    end
    else if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_hold <= 1'b0;
      aw_idx <= 7'h00;
      w_hold <= 1'b0;
      wd <= 16'h0000;
      ws <= 2'b00;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      aw_hold <= next_aw_hold;
      aw_idx <= next_aw_idx;
      w_hold <= next_w_hold;
      wd <= next_wd;
      ws <= next_ws;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Settings words, byte lanes 0 and 1 only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NCFG; i++)
        cfg[i] <= CFG_RESET;
    end
    else if (do_wr)
    begin
      if (ws[0])
        cfg[aw_idx][7:0] <= wd[7:0];
      if (ws[1])
        cfg[aw_idx][15:8] <= wd[15:8];
    end
  end

  //----------------------------------------------------------
  // Pin input filter
  //----------------------------------------------------------
  // Accept a level only once two late stages agree
  always_comb
  begin
    next_dfilt = dfilt;
    for (int i = 0; i < NDIN; i++)
      if (s2[i] == s3[i])
        next_dfilt[i] = s3[i];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dfilt <= '0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dfilt <= next_dfilt;
    end
  end

  //----------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------
  assign mode_on = cfg[IDX_MODE][0];
  assign tick = (tcnt == TCNT_W'(PERIOD_CYCLES - 1));
  assign base = IDX_STEP0 + 7'(idx) * 7'd5; // Step n at 5n-4

  // Digital input: 1..8 pins, 101..114 step results
  function automatic logic dsel(input logic [15:0] s, input logic [NDIN-1:0] p,
                                input logic [NSTEP-1:0] r);
    dsel = 1'b0;
    if (s >= 16'h0001 && s <= 16'h0008)
      dsel = p[3'(s - 16'h0001)];
    else if (s >= SEL_STEP0 && s <= SEL_STEPN)
      dsel = r[4'(s - SEL_STEP0)]; // Fresh if earlier this period
  endfunction : dsel

  // Analog input: 1..4 drive words, 101..114 step values
  always_comb
  begin
    aa = 16'h0000;
    ab = 16'h0000;
    for (int k = 0; k < 2; k++)
    begin
      logic [15:0] s;
      logic [15:0] v;
      s = cfg[base + 7'(k + 1)];
      v = 16'h0000;
      case (s)
        16'h0001: v = ain0;
        16'h0002: v = ain1;
        16'h0003: v = ain2;
        16'h0004: v = ain3;
        default: if (s >= SEL_STEP0 && s <= SEL_STEPN) v = st_ana[4'(s - SEL_STEP0)];
      endcase
      if (k == 0)
        aa = v;
      else
        ab = v;
    end
  end

  assign da = dsel(cfg[base + 7'd1], dfilt, step_result);
  assign db = dsel(cfg[base + 7'd2], dfilt, step_result);

  cls_step u_step (
    .typ(cfg[base]),
    .p1(cfg[base + 7'd3]),
    .p2(cfg[base + 7'd4]),
    .da(da),
    .db(db),
    .aa(aa),
    .ab(ab),
    .pa(st_pa[idx]),
    .pl(st_pl[idx]),
    .lff(st_lff[idx]),
    .tout(st_tout[idx]),
    .cnt(st_cnt[idx]),
    .ana(st_ana[idx]),
    .next_pa(n_pa),
    .next_pl(n_pl),
    .next_lff(n_lff),
    .next_tout(n_tout),
    .next_cnt(n_cnt),
    .next_ana(n_ana)
  );

  // Period tick, then steps one per clock in ascending order
  always_comb
  begin
    next_tcnt = tick ? '0 : tcnt + TCNT_W'(1);
    next_sq = sq;
    next_idx = idx;
    case (sq)
      SQ_IDLE:
      begin
        next_idx = 4'h0;
        if (tick && mode_on)
          next_sq = SQ_RUN;
      end
      SQ_RUN:
      begin
        next_idx = idx + 4'h1;
        if (!mode_on || idx == 4'(NSTEP - 1)) // Fourteen steps
        begin
          next_sq = SQ_IDLE;
          next_idx = 4'h0;
        end
      end
      default:
      begin
        next_sq = SQ_IDLE;
        next_idx = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tcnt <= '0;
      sq <= SQ_IDLE;
      idx <= 4'h0;
    end
    else
    begin
      tcnt <= next_tcnt;
      sq <= next_sq;
      idx <= next_idx;
    end
  end

  // Step state; disabling wipes timers so a restart begins clean
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NSTEP; i++)
      begin
        st_pa[i] <= 1'b0;
        st_pl[i] <= 1'b0;
        st_lff[i] <= 1'b0;
        st_tout[i] <= 1'b0;
        st_cnt[i] <= 16'h0000;
        st_ana[i] <= 16'h0000;
      end
    end
    else if (!mode_on)
    begin
      for (int i = 0; i < NSTEP; i++)
      begin
        st_pa[i] <= 1'b0;
        st_pl[i] <= 1'b0;
        st_lff[i] <= 1'b0;
        st_tout[i] <= 1'b0;
        st_cnt[i] <= 16'h0000;
        st_ana[i] <= 16'h0000;
      end
    end
    else if (sq == SQ_RUN)
    begin
      st_pa[idx] <= n_pa;
      st_pl[idx] <= n_pl;
      st_lff[idx] <= n_lff;
      st_tout[idx] <= n_tout; // Result on own signal
      st_cnt[idx] <= n_cnt;
      st_ana[idx] <= n_ana;
    end
  end

  //----------------------------------------------------------
  // Outputs
  //----------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NOUT; g++)
    begin : g_out
      // Source 1..14 picks a step result, else off
      always_comb
      begin
        next_out[g] = 1'b0;
        if (mode_on && cfg[IDX_OSEL0 + 7'(g)] >= 16'h0001 && cfg[IDX_OSEL0 + 7'(g)] <= 16'(NSTEP))
          next_out[g] = step_result[4'(cfg[IDX_OSEL0 + 7'(g)] - 16'h0001)];
      end
      assign logic_out_function_assign[g] = cfg[IDX_OFUN0 + 7'(g)];
    end
    for (g = 0; g < NSTEP; g++)
    begin : g_res
      assign step_result[g] = st_tout[g];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      logic_out <= '0;
      logic_active <= 1'b0;
    end
    else
    begin
      logic_out <= next_out;
      logic_active <= mode_on;
    end
  end
endmodule : cls_top

// ---- inc/cls_pkg.sv ----
// Purpose: register indices, step type ranges, timing counts
// Assumes: 25 MHz clock, 32-bit AXI4-Lite data, 16-bit settings
// Notes: byte address of a setting is four times its index
package cls_pkg;
  // Geometry
  localparam int unsigned NSTEP = 14;
  localparam int unsigned NOUT = 7;
  localparam int unsigned NDIN = 8;
  localparam int unsigned NAIN = 4;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NCFG = 88;
  // Register indices
  localparam logic [6:0] IDX_MODE = 7'h00;
  localparam logic [6:0] IDX_STEP0 = 7'h01;
  localparam logic [6:0] IDX_STEPN = 7'h46;
  localparam logic [6:0] IDX_OSEL0 = 7'h47;
  localparam logic [6:0] IDX_OSELN = 7'h4d;
  localparam logic [6:0] IDX_OFUN0 = 7'h51;
  localparam logic [6:0] IDX_OFUNN = 7'h57;
  localparam logic [6:0] IDX_STATUS = 7'h62;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Step type ranges
  localparam logic [15:0] DIG_LO = 16'h0001;
  localparam logic [15:0] DIG_HI = 16'h07cf;
  localparam logic [15:0] ANA_LO = 16'h07d1;
  localparam logic [15:0] ANA_HI = 16'h0f9f;
  localparam logic [15:0] MIX_LO = 16'h0fa1;
  localparam logic [15:0] MIX_HI = 16'h176f;
  // Input selector codes
  localparam logic [15:0] SEL_STEP0 = 16'h0065;
  localparam logic [15:0] SEL_STEPN = 16'h0072;
  // Timing
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned PERIOD_MS = 5;
  localparam int unsigned PERIOD_CYC = CLK_HZ / 1000 * PERIOD_MS;
  localparam int unsigned TCNT_W = 17;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Sequencer states
  typedef enum logic [1:0] {SQ_IDLE = 2'b01, SQ_RUN = 2'b10} cls_sq_t;
endpackage : cls_pkg

// ---- rtl/cls_step.sv ----
// Purpose: Combinational evaluator of one sequencer step
// Assumes: called once per step per processing period
// Notes: timer counts are in processing periods
`timescale 1ns/1ps
module cls_step
  import cls_pkg::*;
(
  // Configuration
  input wire logic [15:0] typ,
  input wire logic [15:0] p1,
  input wire logic [15:0] p2,
  // Selected inputs
  input wire logic da,
  input wire logic db,
  input wire logic [15:0] aa,
  input wire logic [15:0] ab,
  // Current state
  input wire logic pa,
  input wire logic pl,
  input wire logic lff,
  input wire logic tout,
  input wire logic [15:0] cnt,
  input wire logic [15:0] ana,
  // Next state
  output logic next_pa,
  output logic next_pl,
  output logic next_lff,
  output logic next_tout,
  output logic [15:0] next_cnt,
  output logic [15:0] next_ana
);
  logic [15:0] fsel;
  logic [15:0] tsel;
  logic lo;
  logic [16:0] sum;
  logic [15:0] cnt1;

  // Evaluate logic, timer and value paths
  always_comb
  begin
    fsel = typ / 16'd10;
    tsel = typ % 16'd10;
    sum = {1'b0, aa} + {1'b0, ab};
    cnt1 = (cnt == 16'hffff) ? cnt : cnt + 16'h0001;
    lo = 1'b0;
    next_pa = da;
    next_pl = 1'b0;
    next_lff = lff;
    next_tout = 1'b0;
    next_cnt = cnt;
    next_ana = 16'h0000;
    if (typ >= DIG_LO && typ <= DIG_HI)
    begin
      // Logic stage: selector divided by ten picks the operation
      case (fsel)
        16'd1: lo = da;
        16'd2: lo = da & db;
        16'd3: lo = da | db;
        16'd4: lo = da ^ db;
        16'd5: lo = da | (~db & lff);
        16'd6: lo = ~db & (da | lff);
        16'd7: lo = da & ~pa;
        16'd8: lo = ~da & pa;
        16'd9: lo = da ^ pa;
        16'd10: lo = db ? lff : da;
        default: lo = 1'b0;
      endcase
      next_lff = lo;
      next_pl = lo;
      if (fsel == 16'd11)
      begin
        // Counter owns cnt; b clears it
        next_cnt = db ? 16'h0000 : ((da & ~pa) ? cnt1 : cnt);
        next_tout = (next_cnt >= p1) & (p1 != 16'h0000);
      end
      else if (fsel >= 16'd1 && fsel <= 16'd10)
      begin
        // Timer stage: units digit picks the variant, p1 is time
        case (tsel)
          16'd1:
          begin
            next_cnt = lo ? cnt1 : 16'h0000;
            next_tout = lo & (next_cnt >= p1);
          end
          16'd2:
          begin
            next_cnt = lo ? 16'h0000 : cnt1;
            next_tout = lo | (tout & (next_cnt < p1));
          end
          16'd3:
          begin
            // Edge only starts a pulse when idle
            if (lo & ~pl & ~tout)
            begin
              next_cnt = 16'h0001;
              next_tout = (p1 != 16'h0000);
            end
            else
            begin
              next_cnt = cnt1;
              next_tout = tout & (cnt < p1);
            end
          end
          16'd4:
          begin
            // Any new edge restarts the pulse
            next_cnt = (lo & ~pl) ? 16'h0001 : cnt1;
            next_tout = (lo & ~pl) ? (p1 != 16'h0000) : (tout & (cnt < p1));
          end
          16'd5:
          begin
            // Alternating pulses while the input is on
            if (!lo)
            begin
              next_cnt = 16'h0000;
              next_tout = 1'b0;
            end
            else if (~pl | (cnt1 >= p1))
            begin
              next_cnt = 16'h0000;
              next_tout = ~pl | ~tout;
            end
            else
            begin
              next_cnt = cnt1;
              next_tout = tout;
            end
          end
          default: next_tout = lo;
        endcase
      end
      else
      begin
        next_tout = 1'b0; // Selector 0 or unused: always off
      end
    end
    else if (typ >= ANA_LO && typ <= ANA_HI)
    begin
      // Value operations; unlisted codes give zero
      case (typ - ANA_LO)
        16'd0: next_ana = sum[16] ? 16'hffff : sum[15:0];
        16'd1: next_ana = (aa > ab) ? aa - ab : 16'h0000;
        16'd2: next_ana = (aa > ab) ? aa : ab;
        16'd3: next_ana = (aa < ab) ? aa : ab;
        16'd4: next_ana = aa;
        16'd5: next_ana = (aa > p1) ? p1 : ((aa < p2) ? p2 : aa);
        default: next_ana = 16'h0000;
      endcase
      next_tout = (next_ana >= p1) & (typ != ANA_LO + 16'd5); // Comparator flag
    end
    else if (typ >= MIX_LO && typ <= MIX_HI)
    begin
      case (typ - MIX_LO)
        16'd0: next_ana = db ? aa : p1;
        16'd1: next_ana = db ? ana : aa;
        16'd2: next_ana = db ? aa : 16'h0000;
        16'd3: next_ana = db ? p2 : p1;
        default: next_ana = 16'h0000;
      endcase
    end
  end
endmodule : cls_step

// ---- test/cls_top_asserts.sv ----
// Purpose: Port-level checks of the logic sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes: sees only top ports; bound at the foot of this file
`timescale 1ns/1ps
module cls_top_asserts
  import cls_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = PERIOD_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sequencer results
  input wire logic logic_active,
  input wire logic [NSTEP-1:0] step_result,
  input wire logic [NOUT-1:0] logic_out
);
  // ----------------------------------------
  // Helper logic and properties
  // ----------------------------------------
  logic [NSTEP-1:0] last_result;
  logic [TCNT_W-1:0] gap;
  logic [TCNT_W-1:0] next_gap;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles since any step result last moved; saturates so a first run passes
  always_comb
    next_gap = (step_result != last_result) ? TCNT_W'(1) : ((gap == '1) ? gap : gap + 1'b1);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      last_result <= '0;
      gap <= '1;
    end
    else
    begin
      last_result <= step_result;
      gap <= next_gap;
    end
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open while a response waits");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while read data waits");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_out_off: assert property (!logic_active [*3] |-> logic_out == '0 && step_result == '0)
    else $error("outputs live while disabled");
  a_result_window: assert property ((step_result != last_result) && logic_active && $past(logic_active)
    |-> (gap <= 16'd13 || gap >= PERIOD_CYCLES - 13))
    else $error("step result moved outside its evaluation window");
  // Main scenarios reached
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_last_step: cover property (step_result[NSTEP-1]);
  c_out_live: cover property (logic_out != '0);
endmodule : cls_top_asserts

bind cls_top cls_top_asserts #(.PERIOD_CYCLES(PERIOD_CYCLES)) chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .logic_active, .step_result, .logic_out);

// ---- test/cls_drive_model.sv ----
// Purpose: Drive-side source of terminal levels and analog words
// Assumes: bench sets wanted levels at rising edges
// Notes: spare analog words carry inverted copies
`timescale 1ns/1ps
module cls_drive_model
  import cls_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wanted levels
  input wire logic [NDIN-1:0] want_din,
  input wire logic [15:0] want_a0,
  input wire logic [15:0] want_a1,
  // Toward the sequencer
  output logic [NDIN-1:0] din,
  output logic [15:0] ain0,
  output logic [15:0] ain1,
  output logic [15:0] ain2,
  output logic [15:0] ain3
);
  // Levels move only at edges, like settled terminals
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {din, ain0, ain1, ain2, ain3} <= '0;
    else
      {din, ain0, ain1, ain2, ain3} <= {want_din, want_a0, want_a1, ~want_a0, ~want_a1};
endmodule : cls_drive_model

// ---- test/cls_top_test.sv ----
// Purpose: Self-checking bench for the logic sequencer
// Assumes: shortened period of 40 clocks
// Notes: bench samples ready and answers at falling edges
`timescale 1ns/1ps
module cls_top_test import cls_pkg::*;;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int unsigned PER = 40;
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, active;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] din, want_din;
  logic [15:0] ain0, ain1, ain2, ain3, want_a0, want_a1;
  logic [NSTEP-1:0] result;
  logic [NOUT-1:0] lout;
  logic [15:0] fassign [NOUT];
  int bad_count = 0, check_count = 0, cyc = 0;
  cls_drive_model drv (.clk, .rst_n, .want_din, .want_a0, .want_a1, .din, .ain0, .ain1, .ain2, .ain3);
  cls_top #(.PERIOD_CYCLES(PER)) uut (.clk, .rst_n, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .din, .ain0, .ain1,
    .ain2, .ain3, .logic_active(active), .step_result(result), .logic_out(lout),
    .logic_out_function_assign(fassign));
  always #20 clk = ~clk;
  // Hang guard counts as a mismatch
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count = bad_count + 1;
      conclude();
    end
  end
  task conclude;
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Bus master: hold each channel until its own ready edge
  task automatic wr(input logic [9:0] idx, input logic [15:0] v, input logic [1:0] er);
    logic ta = 1'b0, tw = 1'b0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge clk);
      ta = ta | awready;
      tw = tw | wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    cmp("bresp", 32'(er), 32'(bresp));
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [31:0] ev, input logic [1:0] er);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    cmp("rdata", ev, rdata);
    cmp("rresp", 32'(er), 32'(rresp));
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd
  // Step n: type, input A, input B, first parameter
  task automatic cfg(input int n, input logic [15:0] t, a, b, p1);
    wr(10'(5 * n - 4), t, RESP_OKAY);
    wr(10'(5 * n - 3), a, RESP_OKAY);
    wr(10'(5 * n - 2), b, RESP_OKAY);
    wr(10'(5 * n - 1), p1, RESP_OKAY);
  endtask : cfg
  // Set inputs, let whole periods pass, then judge step 1
  task automatic probe(input logic [7:0] d, input int np, input logic e, input logic [15:0] a0 = '0, a1 = '0);
    @(posedge clk);
    want_din <= d;
    want_a0 <= a0;
    want_a1 <= a1;
    repeat (np * PER) @(negedge clk);
    cmp("step1_result", 32'(e), 32'(result[0]));
  endtask : probe
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(0, 0, RESP_OKAY);
    rd(70, 0, RESP_OKAY);
    rd(87, 0, RESP_OKAY);
    cmp("logic_out", 0, 32'(lout));
    cmp("logic_active", 0, 32'(active));
  endtask : t_reset
  task automatic t_errors;
    rd(10'h200, 0, RESP_SLVERR);
    wr(98, 16'h0001, RESP_SLVERR);
    rd(92, 0, RESP_SLVERR);
    rd(98, 0, RESP_OKAY);
  endtask : t_errors
  task automatic t_chain;
    cfg(1, 16'd10, 16'd1, 16'd0, 16'd0);
    cfg(14, 16'd10, 16'd101, 16'd0, 16'd0);
    wr(71, 16'd14, RESP_OKAY);
    wr(77, 16'd1, RESP_OKAY);
    wr(81, 16'h00a5, RESP_OKAY);
    wr(87, 16'h005a, RESP_OKAY);
    wr(0, 16'd1, RESP_OKAY);
    probe(8'h01, 3, 1'b1);
    cmp("step_result", 32'h2001, 32'(result));
    cmp("logic_out", 32'h41, 32'(lout));
    cmp("function1", 32'ha5, 32'(fassign[0]));
    cmp("function7", 32'h5a, 32'(fassign[6]));
    @(posedge clk);
    want_din <= 8'h00;
    for (int i = 0; i < 3 * PER && result[0] !== 1'b0; i++) @(negedge clk);
    // Step 1 just fell, so the run is two steps in and step 14 still stale
    rd(98, 32'h6000, RESP_OKAY);
    repeat (15) @(negedge clk);
    cmp("step14_result", 0, 32'(result[13]));
  endtask : t_chain
  task automatic t_off;
    wr(0, 16'd0, RESP_OKAY);
    repeat (4) @(negedge clk);
    cmp("logic_active", 0, 32'(active));
    cmp("logic_out", 0, 32'(lout));
    probe(8'h01, 2, 1'b0);
  endtask : t_off
  task automatic t_timers;
    cfg(1, 16'd11, 16'd1, 16'd0, 16'd3);
    wr(0, 16'd1, RESP_OKAY);
    probe(8'h00, 2, 1'b0);
    probe(8'h01, 2, 1'b0);
    probe(8'h01, 4, 1'b1);
    probe(8'h00, 2, 1'b0);
    cfg(1, 16'd12, 16'd1, 16'd0, 16'd3);
    probe(8'h01, 2, 1'b1);
    probe(8'h00, 2, 1'b1);
    probe(8'h00, 4, 1'b0);
    cfg(1, 16'd13, 16'd1, 16'd0, 16'd3);
    probe(8'h01, 2, 1'b1);
    probe(8'h01, 4, 1'b0);
    cfg(1, 16'd0, 16'd1, 16'd0, 16'd0);
    probe(8'h01, 2, 1'b0);
  endtask : t_timers
  task automatic t_types;
    cfg(1, 16'd2001, 16'd1, 16'd2, 16'd100);
    probe(8'h00, 2, 1'b1, 16'd60, 16'd50);
    probe(8'h00, 2, 1'b0, 16'd60, 16'd30);
    cfg(1, 16'd4001, 16'd1, 16'd1, 16'd0);
    probe(8'h01, 2, 1'b0, 16'd60, 16'd30);
  endtask : t_types
  initial
  begin
    {clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, want_din, want_a0, want_a1} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_errors();
    t_chain();
    t_off();
    t_timers();
    t_types();
    conclude();
  end
endmodule : cls_top_test
